// ---- nv_sram_store_recall_control_test.sv ----
// Purpose: self-checking bench for the nvsram host controller
// Assumes: device model on the far side of the pins
// Notes:   the long store wait is cut short by a reset mid-run
`include "nvsram_host_cfg.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module nv_sram_store_recall_control_test
	import nvsram_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// stimulus, pins and reference state
	logic        i_clock = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        req_valid = 1'b0;
	host_req_t   req = '0;
	logic        req_ready, rsp_valid, busy_o, busy_oe_n, host_oe_n, dev_oe_n, dev_busy_oe_n;
	logic [7:0]  rsp_data, host_io, dev_io;
	logic [7:0]  io_bus = 8'h00;
	logic        supply_ok = 1'b1;  // main supply above trip level
	logic        cap_ok = 1'b1;     // backup charge above trip level
	mem_pins_t   pins;
	wire logic   busy_bus = (busy_oe_n | busy_o) & dev_busy_oe_n; // pulled up
	int          viol, lat;
	int          n_errors = 0;
	int          cmp_count = 0;
	logic [31:0] lfsr = 32'h797b;
	logic [7:0]  ref_mem [2048];
	logic [7:0]  ref_nv [2048];
	logic [10:0] aq [$];
	// data pins: host, then device, else a drifting level
	always @(host_oe_n, dev_oe_n, host_io, dev_io)
		io_bus = !host_oe_n ? host_io : !dev_oe_n ? dev_io : ~io_bus;
	initial forever #5 i_clock = ~i_clock;
	nvsram_host dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_req_valid(req_valid),
		.i_req(req), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
		.o_pins(pins), .i_io_byte(io_bus), .o_io_byte(host_io), .o_io_byte_oe_n(host_oe_n),
		.i_nv_busy_line(busy_bus), .o_nv_busy_line(busy_o), .o_nv_busy_line_oe_n(busy_oe_n));
	nvsram_dev_model far (.i_pins(pins), .i_io_byte(io_bus), .i_nv_busy_line(busy_bus),
		.i_supply_ok(supply_ok), .i_cap_ok(cap_ok), .o_io_byte(dev_io),
		.o_io_byte_oe_n(dev_oe_n), .o_nv_busy_line_oe_n(dev_busy_oe_n), .o_viol(viol));
	// ==========================================================
	// tasks
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic send(input cmd_kind_t k, input logic rc, input logic [10:0] a,
		input logic [7:0] d);
		@(posedge i_clock);
		req_valid <= 1'b1;
		req <= '{kind: k, recall: rc, addr: a, data: d};
		@(posedge i_clock);
		req_valid <= 1'b0;
	endtask
	task automatic wait_rsp(input int lim);
		lat = 0;
		do begin
			@(posedge i_clock);
			#1;
			lat++;
		end while (rsp_valid !== 1'b1 && lat < lim);
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		send(CMD_WRITE, 1'b0, a, d);
		wait_rsp(40);
		`CHK("write latency", `ACCESS_CYC + 4, lat)
		ref_mem[a] = d;
	endtask
	task automatic rd_chk(input logic [10:0] a);
		send(CMD_READ, 1'b0, a, 8'h00);
		wait_rsp(40);
		`CHK("read latency", `ACCESS_CYC + 4, lat)
		`CHK("read data", ref_mem[a], rsp_data)
	endtask
	task automatic recall;
		send(CMD_STORE, 1'b1, 11'h000, 8'h00);
		wait_rsp(3000);
		`CHK("recall done", 1'b1, rsp_valid)
		ref_mem = ref_nv;
	endtask
	task automatic end_of_test;
		if (n_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================================
	// watchdog, well beyond the expected run
	initial begin
		#(40000 * 10);
		n_errors++;
		end_of_test();
	end
	// main sequence
	initial begin
		for (int i = 0; i < 2048; i++)
			ref_nv[i] = i[7:0] ^ 8'h5a;
		ref_mem = ref_nv;
		repeat (4) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		repeat (300) @(posedge i_clock);
		for (int i = 0; i < 16; i++) begin
			lfsr = lfsr_next(lfsr);
			aq.push_back(lfsr[10:0]);
			wr(lfsr[10:0], lfsr[18:11]);
		end
		foreach (aq[i]) rd_chk(aq[i]);
		recall();
		foreach (aq[i]) rd_chk(aq[i]);
		foreach (aq[i]) wr(aq[i], ~ref_mem[aq[i]]);
		// store: busy low, host wait cut by a reset
		send(CMD_STORE, 1'b0, 11'h000, 8'h00);
		lat = 0;
		while (busy_bus !== 1'b0 && lat < 100) begin
			@(posedge i_clock);
			lat++;
		end
		`CHK("busy low", 1'b0, busy_bus)
		ref_nv = ref_mem;
		i_sys_rst <= 1'b1;
		repeat (4) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		lat = 0;
		while (busy_bus !== 1'b1 && lat < 12000) begin
			@(posedge i_clock);
			lat++;
		end
		`CHK("busy high", 1'b1, busy_bus)
		recall();
		foreach (aq[i]) rd_chk(aq[i]);
		`CHK("host slips", 0, viol)
		// low backup charge: software store refused
		cap_ok <= 1'b0;
		send(CMD_STORE, 1'b0, 11'h000, 8'h00);
		repeat (60) @(posedge i_clock);
		`CHK("busy with low cap", 1'b1, busy_bus)
		// supply drop with nothing written since the store: no store
		supply_ok <= 1'b0;
		repeat (20) @(posedge i_clock);
		`CHK("busy after supply drop", 1'b1, busy_bus)
		end_of_test();
	end
endmodule

// ---- nvsram_dev_model.sv ----
// Purpose: behavioural 2Kx8 nonvolatile sram seen from its pins
// Assumes: data and busy pins resolved by the bench, busy pulled up
// Notes:   store and recall times are shortened by parameters
`include "nvsram_host_cfg.svh"
module nvsram_dev_model
	import nvsram_host_pkg::*;
#(
	parameter int STORE_NS  = 100000, // shortened store time
	parameter int RECALL_NS = 2000    // shortened recall time
) (
	// pins from the host
	input  wire mem_pins_t  i_pins,
	input  wire logic [7:0] i_io_byte,
	input  wire logic       i_nv_busy_line,
	// supply and backup charge above the trip level
	input  wire logic       i_supply_ok,
	input  wire logic       i_cap_ok,
	// device drive, low enable drives
	output logic [7:0]      o_io_byte,
	output logic            o_io_byte_oe_n,
	output logic            o_nv_busy_line_oe_n,
	output int              o_viol
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// arrays and sequence state
	logic [7:0]  sram [2048];       // volatile array
	logic [7:0]  nv [2048];         // shadow array
	logic [10:0] seq_tab [5] = '{`SEQ_A0, `SEQ_A1, `SEQ_A2, `SEQ_A3, `SEQ_A4};
	int          step = 0;          // sequence steps matched
	int          viol = 0;          // host slips seen
	logic        nv_mode = 1'b1;    // sram disabled while set
	logic        dirty = 1'b0;      // written since the last store
	logic [10:0] last_addr;         // address before this change
	assign o_viol = viol;
	// read drive, off while writing, deselected or busy
	assign o_io_byte = sram[i_pins.addr];
	assign o_io_byte_oe_n = nv_mode | i_pins.chip_sel_n | i_pins.out_drive_n
		| ~i_pins.write_n;
	// store erases then programs; recall copies back
	task automatic nv_op(input logic st);
		nv_mode = 1'b1;
		if (st)
			dirty = 1'b0;
		o_nv_busy_line_oe_n = ~st;
		#(st ? STORE_NS : RECALL_NS);
		for (int i = 0; i < 2048; i++) begin
			if (st) begin
				nv[i] = 8'h00;
				nv[i] = sram[i];
			end else
				sram[i] = nv[i];
		end
		o_nv_busy_line_oe_n = 1'b1;
		nv_mode = 1'b0;
	endtask
	// power-up recall from a known shadow pattern
	initial begin
		o_nv_busy_line_oe_n = 1'b1;
		for (int i = 0; i < 2048; i++)
			nv[i] = i[7:0] ^ 8'h5a;
		nv_op(1'b0);
	end
	// level write, with slips of the host counted
	always @(i_pins or i_io_byte) begin
		if (!nv_mode && !i_pins.chip_sel_n && !i_pins.write_n) begin
			sram[i_pins.addr] = i_io_byte;
			dirty = 1'b1;
			if (!i_pins.out_drive_n || i_pins.addr != last_addr)
				viol++;
		end
		last_addr = i_pins.addr;
	end
	// each select fall with write high is checked against the next sequence address; one with write low restarts
	always @(negedge i_pins.chip_sel_n) begin
		if (!nv_mode) begin
			if (!i_pins.write_n)
				step = 0;
			else if (step == 5 && (i_pins.addr == `SEQ_STORE || i_pins.addr == `SEQ_RECALL)) begin
				step = 0;
				// low backup charge refuses a software store, not a recall
				if (i_cap_ok || i_pins.addr == `SEQ_RECALL) begin
					fork
						nv_op(i_pins.addr == `SEQ_STORE);
					join_none
				end
			end else if (step < 5 && i_pins.addr == seq_tab[step])
				step++;
			else
				step = (i_pins.addr == `SEQ_A0) ? 1 : 0;
		end
	end
	// supply below trip: cap isolated, one store on its charge if written
	always @(negedge i_supply_ok) begin
		if (!nv_mode && dirty)
			nv_op(1'b1);
	end
	// busy pulled low from outside: store if written and backup charge ok, then stay off until released
	always @(negedge i_nv_busy_line) begin
		if (o_nv_busy_line_oe_n && !nv_mode) begin
			nv_mode = 1'b1;
			if (dirty && i_cap_ok)
				nv_op(1'b1);
			nv_mode = 1'b1;
			wait (i_nv_busy_line === 1'b1);
			nv_mode = 1'b0;
		end
	end
endmodule

// ---- nvsram_host.sv ----
// Purpose: host controller driving a 2Kx8 nonvolatile sram through its pins
// Assumes: inputs synchronous to i_clock; pins resolved by the bench
// Notes:   one request at a time; software store/recall sent as six reads
//
// Notes on behaviour
// - host holds address stable through write
// - host keeps output drive high writing
// - host keeps write strobe inactive idle
// - software store needs six reads
// - no intervening access inside sequence
// - write strobe high during sequence steps
// - host toggles select per sequence step
// - addresses 000 555 2aa 7ff 0f0 70f/70e
`include "nvsram_host_cfg.svh"
module nvsram_host
	import nvsram_host_pkg::*;
(
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_sys_rst,
	// user request side
	input  wire logic        i_req_valid,
	input  wire host_req_t   i_req,
	output logic             o_req_ready,
	output logic             o_rsp_valid,
	output logic [7:0]       o_rsp_data,
	// memory control pins
	output mem_pins_t        o_pins,
	// data byte pins
	input  wire logic [7:0]  i_io_byte,
	output logic [7:0]       o_io_byte,
	output logic             o_io_byte_oe_n,
	// busy line, open drain
	input  wire logic        i_nv_busy_line,
	output logic             o_nv_busy_line,
	output logic             o_nv_busy_line_oe_n
);
	// ==========================================================
	// state and holding registers
	state_t      state_r;                 // controller state
	host_req_t   req_r;                   // accepted request
	logic [2:0]  step_r;                  // sequence step 0..5
	logic [19:0] cnt_r;                   // timing counter
	mem_pins_t   pins_r;                  // pin drive
	logic [7:0]  wdata_r;                 // write data drive
	logic        wdrive_r;                // data bus driven
	logic        busy_drv_r;              // pulling busy line low
	logic        rsp_valid_r;             // answer strobe
	logic [7:0]  rsp_data_r;              // read byte

	localparam logic [19:0] ACC_C   = 20'(`ACCESS_CYC);
	localparam logic [19:0] BUSY_C  = 20'(`BUSY_PULSE_CYC);
	localparam logic [19:0] STORE_C = 20'(`STORE_CYC);
	localparam logic [19:0] REC_C   = 20'(`RECALL_CYC);

	// sequence address for a step, used by the pin drive only
	function automatic logic [10:0] seq_addr(input logic [2:0] s, input logic rec);
		logic [10:0] a;
		a = `SEQ_A0;
		case (s)
			3'h1: a = `SEQ_A1;
			3'h2: a = `SEQ_A2;
			3'h3: a = `SEQ_A3;
			3'h4: a = `SEQ_A4;
			3'h5: a = rec ? `SEQ_RECALL : `SEQ_STORE;
			default: a = `SEQ_A0;
		endcase
		return a;
	endfunction

	wire is_seq   = (req_r.kind == CMD_STORE);
	wire cnt_zero = (cnt_r == 20'h0);

	assign o_req_ready = (state_r == ST_IDLE);

	// ==========================================================
	// state machine
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r <= ST_IDLE;
			step_r  <= 3'h0;
			cnt_r   <= 20'h0;
		end else begin
			case (state_r)
				// take a request
				ST_IDLE: begin
					if (i_req_valid) begin
						state_r <= ST_SETUP;
						step_r  <= 3'h0;
						cnt_r   <= 20'h0;
					end
				end
				// address settles with select high
				ST_SETUP: begin
					state_r <= ST_PULSE;
					cnt_r   <= ACC_C;
				end
				// select low for full access time
				ST_PULSE: begin
					if (cnt_zero) begin
						state_r <= ST_GAP;
					end else begin
						cnt_r <= cnt_r - 20'h1;
					end
				end
				// select high again between steps
				ST_GAP: begin
					if (is_seq && step_r != 3'h5) begin
						step_r  <= step_r + 3'h1;
						state_r <= ST_SETUP;
					end else if (is_seq) begin
						state_r <= ST_WAIT;
						cnt_r   <= req_r.recall ? REC_C : STORE_C;
					end else begin
						state_r <= ST_DONE;
					end
				end
				// nonvolatile cycle: keep off the bus
				ST_WAIT: begin
					if (cnt_zero && i_nv_busy_line) begin
						state_r <= ST_DONE;
					end else if (!cnt_zero) begin
						cnt_r <= cnt_r - 20'h1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// accepted request capture
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			req_r <= '0;
		end else if (state_r == ST_IDLE && i_req_valid) begin
			req_r <= i_req;
		end
	end

	// ==========================================================
	// pin drive; strobes idle high, address changes only with select high
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pins_r   <= '{chip_sel_n: 1'b1, out_drive_n: 1'b1, write_n: 1'b1,
			              addr: 11'h000};
			wdata_r  <= 8'h00;
			wdrive_r <= 1'b0;
		end else begin
			pins_r.chip_sel_n  <= !(state_r == ST_SETUP ||
			                        (state_r == ST_PULSE && !cnt_zero));
			// write strobe only for plain writes; high in sequences
			pins_r.write_n     <= !(req_r.kind == CMD_WRITE &&
			                        (state_r == ST_SETUP ||
			                         (state_r == ST_PULSE && !cnt_zero)));
			pins_r.out_drive_n <= !(req_r.kind != CMD_WRITE &&
			                        (state_r == ST_SETUP || state_r == ST_PULSE));
			if (state_r == ST_IDLE && i_req_valid) begin
				pins_r.addr <= (i_req.kind == CMD_STORE) ? `SEQ_A0 : i_req.addr;
			end else if (state_r == ST_GAP && is_seq && step_r != 3'h5) begin
				pins_r.addr <= seq_addr(step_r + 3'h1, req_r.recall);
			end
			// address held until strobe rises
			wdrive_r <= (req_r.kind == CMD_WRITE) &&
			            (state_r == ST_SETUP || state_r == ST_PULSE);
			wdata_r  <= req_r.data;
		end
	end

	// ==========================================================
	// busy line drive, never pulled low (no hardware store request sent)
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			busy_drv_r <= 1'b0;
		end else begin
			busy_drv_r <= 1'b0;
		end
	end

	// ==========================================================
	// read answer
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= 8'h00;
		end else begin
			rsp_valid_r <= (state_r == ST_DONE);
			if (state_r == ST_PULSE && cnt_zero && req_r.kind == CMD_READ) begin
				rsp_data_r <= i_io_byte;
			end
		end
	end

	assign o_pins              = pins_r;
	assign o_io_byte           = wdata_r;
	assign o_io_byte_oe_n      = !wdrive_r;
	assign o_nv_busy_line      = 1'b0;
	assign o_nv_busy_line_oe_n = !busy_drv_r;
	assign o_rsp_valid         = rsp_valid_r;
	assign o_rsp_data          = rsp_data_r;

	// ==========================================================
	// checks
	AST_WR_NO_DRIVE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!o_pins.write_n |-> o_pins.out_drive_n)
		else $error("output drive low during write");
	AST_SEQ_NO_WRITE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(is_seq && state_r != ST_IDLE) |-> o_pins.write_n)
		else $error("write strobe low in sequence");
	AST_ADDR_STABLE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(!o_pins.chip_sel_n && $past(!o_pins.chip_sel_n)) |-> $stable(o_pins.addr))
		else $error("address moved under select");
	AST_SIXTH_ADDR: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(state_r == ST_PULSE && is_seq && step_r == 3'h5) |->
		o_pins.addr == (req_r.recall ? `SEQ_RECALL : `SEQ_STORE))
		else $error("wrong sixth address");
	AST_SEL_TOGGLE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(state_r == ST_GAP) |=> o_pins.chip_sel_n)
		else $error("select not raised between steps");
	AST_IDLE_STROBE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(state_r == ST_IDLE && $past(state_r) == ST_IDLE) |-> o_pins.write_n)
		else $error("write strobe active while idle");
	AST_RSP_AFTER: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(state_r == ST_DONE) |=> o_rsp_valid ##1 !o_rsp_valid)
		else $error("answer strobe wrong");
	AST_NO_BUS_NV: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(state_r == ST_WAIT) |-> (o_pins.chip_sel_n && o_io_byte_oe_n))
		else $error("access during nonvolatile cycle");
	COV_READ:   cover property (@(posedge i_clock) state_r == ST_DONE && req_r.kind == CMD_READ);
	COV_WRITE:  cover property (@(posedge i_clock) state_r == ST_DONE && req_r.kind == CMD_WRITE);
	COV_STORE:  cover property (@(posedge i_clock) state_r == ST_WAIT && !req_r.recall);
	COV_RECALL: cover property (@(posedge i_clock) state_r == ST_WAIT && req_r.recall);
endmodule

// ---- nvsram_host_cfg.svh ----
// Purpose: constants for the nvsram host controller
// Assumes: 100 MHz clock
// Notes:   timing counts derived from printed times
`ifndef NVSRAM_HOST_CFG_SVH
`define NVSRAM_HOST_CFG_SVH
// ==========================================================
// sequence addresses
`define SEQ_A0        11'h000
`define SEQ_A1        11'h555
`define SEQ_A2        11'h2aa
`define SEQ_A3        11'h7ff
`define SEQ_A4        11'h0f0
`define SEQ_STORE     11'h70f
`define SEQ_RECALL    11'h70e
// ==========================================================
// timing (ns, us, ms) and cycle counts at 10 ns
`define CLK_NS        10
`define ACCESS_NS     50
`define ACCESS_CYC    ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define BUSY_PULSE_NS  250
`define BUSY_PULSE_CYC ((`BUSY_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define STORE_MS      10
`define STORE_CYC     (`STORE_MS * 1000000 / `CLK_NS)
`define RECALL_US     20
`define RECALL_CYC    (`RECALL_US * 1000 / `CLK_NS)
`endif

// ---- nvsram_host_pkg.sv ----
// Purpose: types for the nvsram host controller
// Assumes: nothing
// Notes:   one-hot state codes
package nvsram_host_pkg;
	// ==========================================================
	// host command kinds
	typedef enum logic [2:0] {
		CMD_READ   = 3'h1,
		CMD_WRITE  = 3'h2,
		CMD_STORE  = 3'h4
	} cmd_kind_t;
	// request carrier
	typedef struct packed {
		cmd_kind_t   kind;
		logic        recall;
		logic [10:0] addr;
		logic [7:0]  data;
	} host_req_t;
	// memory pin carrier
	typedef struct packed {
		logic        chip_sel_n;
		logic        out_drive_n;
		logic        write_n;
		logic [10:0] addr;
	} mem_pins_t;
	// controller states
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_SETUP = 7'h02,
		ST_PULSE = 7'h04,
		ST_GAP   = 7'h08,
		ST_BUSY  = 7'h10,
		ST_WAIT  = 7'h20,
		ST_DONE  = 7'h40
	} state_t;
endpackage
